// File: dsm_pkg.sv
package dsm_pkg;

    typedef enum logic [2:0] {
        MODE_DBPSK,
        MODE_DQPSK,
        MODE_BMBOK,
        MODE_QMBOK,
        MODE_CCK55,
        MODE_CCK11
    } dsm_mode_t;

    typedef enum logic {
        ENG_IDLE,
        ENG_SEND
    } dsm_eng_t;

endpackage

// File: dsm_regs.svh
// What this block does
// [RULE1] Scrambler is a 7-bit shift register with software-programmed feedback taps.
// [RULE2] Preamble, header and data are all scrambled; all-zero taps pass data unchanged.
// [RULE3] Output bit is input XOR sum of enabled taps; register keeps output bits.
// [RULE4] Scrambler register loads seed 6C hex at each transmission start.
// [RULE5] Receive descrambler uses the same tap configuration and needs no seed.
// [RULE6] DBPSK and header bits are differentially encoded, driving I and Q alike.
// [RULE7] DQPSK dibit 00/01/11/10 gives phase change 0/+90/+180/-90 degrees.
// [RULE8] Rotation counterclockwise; bits 5 and 6 reverse transmit and receive sense.
// [RULE9] DQPSK puts one bit on I, one on Q; both spread by Barker word.
// [RULE10] Bi-orthogonal modes use undifferenced nibbles: one per symbol binary, two quaternary.
// [RULE11] Binary mode: three magnitude bits pick Walsh code, sign inverts, drives I and Q.
// [RULE12] Modified Walsh codes are 03,0C,30,3F,56,59,65,6A hex.
// [RULE13] Walsh chips go out at chip rate, eight chips per symbol.
// [RULE14] Encoder output of last header bit is latched, XORed onto bi-orthogonal data.
// [RULE15] Quaternary mode: first nibble code to Q, second to I, both phase-referenced.
// [RULE16] Complementary symbol is eight complex chips, first chip first, phase chip last.
// [RULE17] Chip phases add phi1 all, phi2 odd chips, phi3 odd pairs, phi4 quads.
// [RULE18] Phi1 is DQPSK coded; odd payload symbols get extra pi, counted from zero.
// [RULE19] 5.5 Mbps: first dibit phi1; phi2=d2*pi+pi/2, phi3=0, phi4=d3*pi.
// [RULE20] 11 Mbps: eight bits per symbol; dibits set phi2..phi4 by binary mapping.
// [RULE21] Phi1 change is referenced to the preceding symbol's phi1.
// [RULE22] Preamble and header go as DBPSK, payload switches rate automatically.
// [RULE23] Two-bit rate select: 00 1M, 01 2M, 10 5.5M, 11 11M.
// [RULE24] Preamble bits are all ones before scrambling and always DBPSK.
// [RULE25] A setting picks Walsh or complementary keying, held stable through a packet.
// [RULE26] One I/Q chip per chip enable; reset returns scrambler, encoder, counters.
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DSM_REG_TAPS      4'h0
`define DSM_REG_CTRL      4'h1
`define DSM_REG_ROT       4'h2
`define DSM_REG_STATUS    4'h3

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DSM_CTRL_RATE_LO  0
`define DSM_CTRL_RATE_HI  1
`define DSM_CTRL_KEY_BIT  2
`define DSM_ROT_TX_BIT    5
`define DSM_ROT_RX_BIT    6
`define DSM_TAPS_RST      7'h00
`define DSM_CTRL_RST      3'h0
`define DSM_SEED          7'h6C

// ----------------------------------------
// Spreading constants
// ----------------------------------------
`define DSM_BARKER        11'h712
`define DSM_BARKER_LEN    4'hB
`define DSM_SYM8_LEN      4'h8
`define DSM_WALSH_0       8'h03
`define DSM_WALSH_1       8'h0C
`define DSM_WALSH_2       8'h30
`define DSM_WALSH_3       8'h3F
`define DSM_WALSH_4       8'h56
`define DSM_WALSH_5       8'h59
`define DSM_WALSH_6       8'h65
`define DSM_WALSH_7       8'h6A

`endif

// File: dsm_tx_modulator.sv
`timescale 1ns/1ps
`include "dsm_regs.svh"

module dsm_tx_modulator #(
    parameter int          ADDR_W = 4,
    parameter logic [6:0]  SEED   = `DSM_SEED
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    input  wire logic              i_chip_en,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [7:0]             o_rdata,
    input  wire logic              i_tx_start,
    input  wire logic              i_bit_valid,
    input  wire logic              i_bit,
    input  wire logic              i_bit_pre,
    input  wire logic              i_bit_payload,
    input  wire logic              i_bit_hdr_last,
    output logic                   o_bit_ready,
    output logic                   o_chip_valid,
    output logic                   o_chip_i,
    output logic                   o_chip_q,
    output logic [6:0]             o_scr_taps,
    output logic                   o_rx_rot_rev
);

    generate
        if (ADDR_W < 2 || ADDR_W > 8) begin : g_bad_addr
            $error("dsm_tx_modulator: ADDR_W must be 2..8");
        end
    endgenerate

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] quad_to_iq(input logic [1:0] quad);
        // Bit 1 means a -1 chip; {i, q}
        return {quad[1] ^ quad[0], quad[1]};
    endfunction

    function automatic logic [7:0] walsh(input logic [2:0] mag);
        logic [7:0] w;
        case (mag)
            3'd0:    w = `DSM_WALSH_0;
            3'd1:    w = `DSM_WALSH_1;
            3'd2:    w = `DSM_WALSH_2;
            3'd3:    w = `DSM_WALSH_3;
            3'd4:    w = `DSM_WALSH_4;
            3'd5:    w = `DSM_WALSH_5;
            3'd6:    w = `DSM_WALSH_6;
            default: w = `DSM_WALSH_7;
        endcase
        return w; // [RULE12]
    endfunction

    function automatic logic [1:0] dq_delta(input logic d0, input logic d1, input logic rev);
        logic [1:0] dl;
        case ({d0, d1})
            2'b00:   dl = 2'd0;
            2'b01:   dl = 2'd1;
            2'b11:   dl = 2'd2;
            default: dl = 2'd3;
        endcase
        return rev ? 2'(-dl) : dl; // [RULE7] [RULE8]
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [6:0]            taps_reg;
    logic [2:0]            ctrl_reg;
    logic                  rot_tx_reg;
    logic                  rot_rx_reg;
    logic [1:0]            rate_pkt_reg;
    logic                  key_pkt_reg;
    logic [7:0]            rdata_reg;
    logic [7:0]            status;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            taps_reg   <= `DSM_TAPS_RST;
            ctrl_reg   <= `DSM_CTRL_RST;
            rot_tx_reg <= 1'b0;
            rot_rx_reg <= 1'b0;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                ADDR_W'(`DSM_REG_TAPS): taps_reg <= i_wdata[6:0]; // [RULE1]
                ADDR_W'(`DSM_REG_CTRL): ctrl_reg <= i_wdata[2:0]; // [RULE23] [RULE25]
                ADDR_W'(`DSM_REG_ROT): begin
                    rot_tx_reg <= i_wdata[`DSM_ROT_TX_BIT]; // [RULE8]
                    rot_rx_reg <= i_wdata[`DSM_ROT_RX_BIT];
                end
                default: ;
            endcase
        end
    end

    // Rate and keying frozen for the whole packet
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rate_pkt_reg <= 2'b00;
            key_pkt_reg  <= 1'b0;
        end else if (i_ce && i_tx_start) begin
            rate_pkt_reg <= ctrl_reg[`DSM_CTRL_RATE_HI:`DSM_CTRL_RATE_LO]; // [RULE23]
            key_pkt_reg  <= ctrl_reg[`DSM_CTRL_KEY_BIT]; // [RULE25]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rdata_reg <= 8'h00;
        end else if (i_ce && i_rd) begin
            case (i_addr)
                ADDR_W'(`DSM_REG_TAPS):   rdata_reg <= {1'b0, taps_reg};
                ADDR_W'(`DSM_REG_CTRL):   rdata_reg <= {5'h00, ctrl_reg};
                ADDR_W'(`DSM_REG_ROT):    rdata_reg <= {1'b0, rot_rx_reg, rot_tx_reg, 5'h00};
                ADDR_W'(`DSM_REG_STATUS): rdata_reg <= status;
                default:                  rdata_reg <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Scrambler and bit collector
    // ----------------------------------------
    logic [6:0]            scr_reg;
    logic [7:0]            col_bits_reg;
    logic [3:0]            col_cnt_reg;
    logic [3:0]            col_need_reg;
    dsm_pkg::dsm_mode_t    col_mode_reg;
    logic                  col_pay_reg;
    logic                  col_hl_reg;
    logic                  full_reg;
    logic                  ready_reg;
    logic                  accept;
    logic                  load;
    logic                  scr_in;
    logic                  scr_out;
    dsm_pkg::dsm_mode_t    first_mode;
    logic [3:0]            first_need;
    logic [3:0]            cnt_now;
    logic [3:0]            need_now;
    logic                  full_next;

    assign accept  = i_bit_valid && ready_reg && !i_tx_start;
    assign scr_in  = i_bit_pre ? 1'b1 : i_bit; // [RULE24]
    assign scr_out = scr_in ^ (^(scr_reg & taps_reg)); // [RULE3] [RULE2]

    always_comb begin
        first_mode = dsm_pkg::MODE_DBPSK;
        if (i_bit_payload) begin // [RULE22]
            case (rate_pkt_reg)
                2'b00:   first_mode = dsm_pkg::MODE_DBPSK;
                2'b01:   first_mode = dsm_pkg::MODE_DQPSK;
                2'b10:   first_mode = key_pkt_reg ? dsm_pkg::MODE_CCK55 : dsm_pkg::MODE_BMBOK;
                default: first_mode = key_pkt_reg ? dsm_pkg::MODE_CCK11 : dsm_pkg::MODE_QMBOK;
            endcase
        end
        case (first_mode)
            dsm_pkg::MODE_DBPSK: first_need = 4'd1;
            dsm_pkg::MODE_DQPSK: first_need = 4'd2;
            dsm_pkg::MODE_BMBOK,
            dsm_pkg::MODE_CCK55: first_need = 4'd4; // [RULE10]
            default:             first_need = 4'd8; // [RULE20]
        endcase
        cnt_now   = col_cnt_reg + 4'd1;
        need_now  = (col_cnt_reg == 4'd0) ? first_need : col_need_reg;
        full_next = load ? 1'b0 : full_reg;
        if (accept && cnt_now == need_now) begin
            full_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            scr_reg <= SEED;
        end else if (i_ce) begin
            if (i_tx_start) begin
                scr_reg <= SEED; // [RULE4]
            end else if (accept) begin
                scr_reg <= {scr_reg[5:0], scr_out}; // [RULE3]
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            col_bits_reg <= 8'h00;
            col_cnt_reg  <= 4'd0;
            col_need_reg <= 4'd1;
            col_mode_reg <= dsm_pkg::MODE_DBPSK;
            col_pay_reg  <= 1'b0;
            col_hl_reg   <= 1'b0;
            full_reg     <= 1'b0;
            ready_reg    <= 1'b0;
        end else if (i_ce) begin
            if (i_tx_start) begin
                col_cnt_reg <= 4'd0;
                full_reg    <= 1'b0;
                ready_reg   <= 1'b1;
            end else begin
                if (load) begin
                    col_cnt_reg <= 4'd0;
                end
                if (accept) begin
                    col_bits_reg[col_cnt_reg[2:0]] <= scr_out;
                    col_cnt_reg                    <= cnt_now;
                    if (col_cnt_reg == 4'd0) begin
                        col_need_reg <= first_need;
                        col_mode_reg <= first_mode;
                        col_pay_reg  <= i_bit_payload;
                        col_hl_reg   <= i_bit_hdr_last;
                    end
                end
                full_reg  <= full_next;
                ready_reg <= !full_next;
            end
        end
    end

    // ----------------------------------------
    // Symbol encoder
    // ----------------------------------------
    logic [1:0]            ph_reg;
    logic                  ref_reg;
    logic                  odd_reg;
    logic [1:0]            ph_new;
    logic [10:0]           sym_i;
    logic [10:0]           sym_q;
    logic [3:0]            sym_len;
    logic [1:0]            iq;
    logic [1:0]            phi2;
    logic [1:0]            phi3;
    logic [1:0]            phi4;
    logic [1:0]            cp;
    logic [7:0]            w_a;
    logic [7:0]            w_b;
    logic [2:0]            k3;
    logic                  is_cck;

    always_comb begin
        ph_new  = ph_reg;
        sym_i   = 11'h000;
        sym_q   = 11'h000;
        sym_len = `DSM_SYM8_LEN;
        phi2    = 2'd0;
        phi3    = 2'd0;
        phi4    = 2'd0;
        cp      = 2'd0;
        k3      = 3'd0;
        is_cck  = 1'b0;
        w_a     = walsh(col_bits_reg[2:0]) ^ {8{col_bits_reg[3] ^ ref_reg}}; // [RULE11] [RULE14]
        w_b     = walsh(col_bits_reg[6:4]) ^ {8{col_bits_reg[7] ^ ref_reg}};
        case (col_mode_reg)
            dsm_pkg::MODE_DBPSK: begin
                ph_new  = ph_reg + {col_bits_reg[0], 1'b0}; // [RULE6]
                sym_len = `DSM_BARKER_LEN;
            end
            dsm_pkg::MODE_DQPSK: begin
                ph_new  = ph_reg + dq_delta(col_bits_reg[0], col_bits_reg[1], rot_tx_reg);
                sym_len = `DSM_BARKER_LEN;
            end
            dsm_pkg::MODE_BMBOK: begin
                sym_i = {3'b000, w_a}; // [RULE11] [RULE13]
                sym_q = {3'b000, w_a};
            end
            dsm_pkg::MODE_QMBOK: begin
                sym_q = {3'b000, w_a}; // [RULE15]
                sym_i = {3'b000, w_b};
            end
            dsm_pkg::MODE_CCK55: begin
                is_cck = 1'b1;
                phi2   = {col_bits_reg[2], 1'b1}; // [RULE19]
                phi4   = {col_bits_reg[3], 1'b0};
            end
            dsm_pkg::MODE_CCK11: begin
                is_cck = 1'b1;
                phi2   = {col_bits_reg[2], col_bits_reg[3]}; // [RULE20]
                phi3   = {col_bits_reg[4], col_bits_reg[5]};
                phi4   = {col_bits_reg[6], col_bits_reg[7]};
            end
            default: ;
        endcase
        iq = quad_to_iq(ph_new);
        if (sym_len == `DSM_BARKER_LEN) begin
            sym_i = `DSM_BARKER ^ {11{iq[1]}}; // [RULE9] [RULE6]
            sym_q = `DSM_BARKER ^ {11{iq[0]}};
        end
        if (is_cck) begin
            ph_new = ph_reg + dq_delta(col_bits_reg[0], col_bits_reg[1], rot_tx_reg)
                   + {odd_reg, 1'b0}; // [RULE18] [RULE21]
            for (int k = 0; k < 8; k++) begin
                k3 = 3'(k);
                cp = ph_new; // [RULE17]
                if (!k3[0]) cp = cp + phi2;
                if (!k3[1]) cp = cp + phi3;
                if (!k3[2]) cp = cp + phi4;
                if (k3 == 3'd3 || k3 == 3'd6) cp = cp + 2'd2;
                iq       = quad_to_iq(cp);
                sym_i[k] = iq[1]; // [RULE16]
                sym_q[k] = iq[0];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ph_reg  <= 2'd0;
            ref_reg <= 1'b0;
            odd_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_tx_start) begin
                ph_reg  <= 2'd0;
                odd_reg <= 1'b0;
            end else if (load) begin
                ph_reg <= ph_new; // [RULE21]
                if (col_hl_reg) begin
                    ref_reg <= ph_new[1]; // [RULE14]
                end
                odd_reg <= col_pay_reg ? !odd_reg : 1'b0; // [RULE18]
            end
        end
    end

    // ----------------------------------------
    // Chip engine
    // ----------------------------------------
    dsm_pkg::dsm_eng_t     eng_reg;
    logic [10:0]           chi_reg;
    logic [10:0]           chq_reg;
    logic [3:0]            left_reg;
    logic                  last_chip;
    logic                  vld_reg;
    logic                  ci_reg;
    logic                  cq_reg;

    assign last_chip = (eng_reg == dsm_pkg::ENG_SEND) && i_chip_en && left_reg == 4'd1;
    assign load      = full_reg && !i_tx_start
                     && (eng_reg == dsm_pkg::ENG_IDLE || last_chip);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            eng_reg  <= dsm_pkg::ENG_IDLE;
            chi_reg  <= 11'h000;
            chq_reg  <= 11'h000;
            left_reg <= 4'd0;
        end else if (i_ce) begin
            case (eng_reg)
                dsm_pkg::ENG_IDLE: begin
                    if (load) begin
                        chi_reg  <= sym_i;
                        chq_reg  <= sym_q;
                        left_reg <= sym_len;
                        eng_reg  <= dsm_pkg::ENG_SEND;
                    end
                end
                dsm_pkg::ENG_SEND: begin
                    if (load) begin
                        chi_reg  <= sym_i;
                        chq_reg  <= sym_q;
                        left_reg <= sym_len;
                    end else if (i_chip_en) begin
                        chi_reg  <= {1'b0, chi_reg[10:1]};
                        chq_reg  <= {1'b0, chq_reg[10:1]};
                        left_reg <= left_reg - 4'd1;
                        if (left_reg == 4'd1) begin
                            eng_reg <= dsm_pkg::ENG_IDLE;
                        end
                    end
                end
                default: eng_reg <= dsm_pkg::ENG_IDLE;
            endcase
        end
    end

    // One chip pair per chip enable, first chip first
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            vld_reg <= 1'b0;
            ci_reg  <= 1'b0;
            cq_reg  <= 1'b0;
        end else if (i_ce) begin
            vld_reg <= i_chip_en && eng_reg == dsm_pkg::ENG_SEND; // [RULE26]
            if (i_chip_en && eng_reg == dsm_pkg::ENG_SEND) begin
                ci_reg <= chi_reg[0]; // [RULE16] [RULE13]
                cq_reg <= chq_reg[0];
            end
        end
    end

    assign status = {1'b0, rate_pkt_reg, key_pkt_reg, odd_reg, ref_reg, full_reg,
                     eng_reg == dsm_pkg::ENG_SEND};

    assign o_rdata      = rdata_reg;
    assign o_bit_ready  = ready_reg;
    assign o_chip_valid = vld_reg;
    assign o_chip_i     = ci_reg;
    assign o_chip_q     = cq_reg;
    assign o_scr_taps   = taps_reg;   // [RULE5]
    assign o_rx_rot_rev = rot_rx_reg; // [RULE8]

endmodule // dsm_tx_modulator

// File: dsm_tx_modulator_sva.sv
`timescale 1ns/1ps

module dsm_tx_modulator_sva #(
    parameter int ADDR_W = 4
) (
    input wire logic              i_clk_sys,
    input wire logic              i_rstn,
    input wire logic              i_ce,
    input wire logic              i_chip_en,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [7:0]        o_rdata,
    input wire logic              i_tx_start,
    input wire logic              o_bit_ready,
    input wire logic              o_chip_valid,
    input wire logic              o_chip_i,
    input wire logic              o_chip_q,
    input wire logic [6:0]        o_scr_taps,
    input wire logic              o_rx_rot_rev
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    sequence s_start;
        i_ce && i_tx_start;
    endsequence

    sequence s_no_chip;
        i_ce && !i_chip_en;
    endsequence

    property p_tap_wr;
        logic [7:0] v;
        (i_ce && i_wr && i_addr == 4'h0, v = i_wdata) |=> o_scr_taps == v[6:0];
    endproperty

    property p_rot_wr;
        logic [7:0] v;
        (i_ce && i_wr && i_addr == 4'h2, v = i_wdata) |=> o_rx_rot_rev == v[6];
    endproperty

    a_chip_cause: assert property (o_chip_valid && $past(i_ce) |-> $past(i_chip_en))
        else $error("chip valid without chip enable");
    a_chip_quiet: assert property (s_no_chip |=> !o_chip_valid && $stable(o_chip_i) && $stable(o_chip_q))
        else $error("chip moved without enable");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_chip_valid) && $stable(o_bit_ready)
        && $stable(o_rdata) && $stable(o_scr_taps))
        else $error("frozen state moved");
    a_ready_start: assert property (s_start |=> o_bit_ready)
        else $error("bit ready missing after start");
    a_tap_write: assert property (p_tap_wr)
        else $error("taps not taken");
    a_rot_write: assert property (p_rot_wr)
        else $error("rx rotation not taken");
    a_tap_read: assert property (i_ce && i_rd && i_addr == 4'h0 |=> o_rdata == {1'b0, o_scr_taps})
        else $error("tap readback wrong");
    a_rdata_hold: assert property (i_ce && !i_rd |=> $stable(o_rdata))
        else $error("read data changed without read");
endmodule // dsm_tx_modulator_sva

bind dsm_tx_modulator dsm_tx_modulator_sva #(.ADDR_W(ADDR_W)) u_sva (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_chip_en(i_chip_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_start(i_tx_start), .o_bit_ready(o_bit_ready), .o_chip_valid(o_chip_valid),
    .o_chip_i(o_chip_i), .o_chip_q(o_chip_q), .o_scr_taps(o_scr_taps), .o_rx_rot_rev(o_rx_rot_rev)
);

// File: dsm_upconv_model.sv
`timescale 1ns/1ps

module dsm_upconv_model (
    input wire logic i_clk_sys,
    input wire logic i_chip_valid,
    input wire logic i_chip_i,
    input wire logic i_chip_q
);
    logic [1:0] chips[$];

    // Takes each chip pair in its valid cycle
    always @(posedge i_clk_sys) begin
        if (i_chip_valid === 1'b1) begin
            chips.push_back({i_chip_i, i_chip_q});
        end
    end
endmodule // dsm_upconv_model

// File: tb_dsss_tx_scrambler_modulator.sv
`timescale 1ns/1ps
`include "dsm_regs.svh"

module tb_dsss_tx_scrambler_modulator;
    logic       clk = 1'b0, rstn = 1'b0, ce = 1'b1, chip_en = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       start = 1'b0, bvalid = 1'b0, bit_v = 1'b0, bpre = 1'b0, bpay = 1'b0, blast = 1'b0;
    logic       ready, cvalid, ci, cq, rxrev, grp_pay, key, rev, odd;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, d, grp;
    logic [6:0] taps, s, tp;
    logic [1:0] q, rate, cdiv = 2'h0;
    logic [1:0] exq[$];
    logic [7:0] wt[8] = '{8'h03, 8'h0C, 8'h30, 8'h3F, 8'h56, 8'h59, 8'h65, 8'h6A};
    int         error_cnt = 0, check_count = 0, grp_n;

    dsm_tx_modulator dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_chip_en(chip_en), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_start(start),
        .i_bit_valid(bvalid), .i_bit(bit_v), .i_bit_pre(bpre), .i_bit_payload(bpay),
        .i_bit_hdr_last(blast), .o_bit_ready(ready), .o_chip_valid(cvalid), .o_chip_i(ci),
        .o_chip_q(cq), .o_scr_taps(taps), .o_rx_rot_rev(rxrev)
    );
    dsm_upconv_model up (.i_clk_sys(clk), .i_chip_valid(cvalid), .i_chip_i(ci), .i_chip_q(cq));
    initial forever #10 clk = ~clk;

    always @(posedge clk) begin
        cdiv    <= cdiv + 2'h1;
        chip_en <= (cdiv == 2'h3);
    end

    task automatic check(string nm, logic [7:0] got, logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic give_up();
        error_cnt++;
        wrap_up();
    endtask

    task automatic bus_wr(logic [3:0] a, logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_rd(logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask

    // ----------------------------------------
    // Reference chip model
    // ----------------------------------------
    function automatic void emit(logic [1:0] p);
        exq.push_back({p[1] ^ p[0], p[1]});
    endfunction

    function automatic void sym();
        logic [10:0] bk;
        logic [7:0]  w1, w2;
        logic [1:0]  inc, p2, p3, p4;
        bk  = `DSM_BARKER;
        w1  = wt[grp[2:0]] ^ {8{grp[3] ^ q[1]}};
        w2  = wt[grp[6:4]] ^ {8{grp[7] ^ q[1]}};
        inc = {grp[0], grp[0] ^ grp[1]};
        inc = rev ? 2'h0 - inc : inc;
        p2  = rate[0] ? {grp[2], grp[3]} : {grp[2], 1'b1};
        p3  = rate[0] ? {grp[4], grp[5]} : 2'h0;
        p4  = rate[0] ? {grp[6], grp[7]} : {grp[3], 1'b0};
        if (!grp_pay || rate < 2'h2) begin
            q = q + ((grp_pay && rate == 2'h1) ? inc : {grp[0], 1'b0});
            for (int k = 0; k < 11; k++)
                emit(q + {bk[k], 1'b0});
        end else if (!key) begin
            for (int k = 0; k < 8; k++)
                exq.push_back(rate[0] ? {w2[k], w1[k]} : {2{w1[k]}});
        end else begin
            q   = q + inc + {odd, 1'b0};
            odd = ~odd;
            for (int k = 0; k < 8; k++)
                emit(q + (k[0] ? 2'h0 : p2) + (k[1] ? 2'h0 : p3) + (k[2] ? 2'h0 : p4)
                     + ((k == 3 || k == 6) ? 2'h2 : 2'h0));
        end
    endfunction

    task automatic send(logic b, logic pre, logic pay, logic last);
        logic m;
        int   n;
        m = (pre | b) ^ (^(s & tp));
        s = {s[5:0], m};
        if (grp_n == 0)
            grp_pay = pay;
        grp[grp_n] = m;
        grp_n++;
        if (grp_n == (grp_pay ? 1 << rate : 1)) begin
            sym();
            grp_n = 0;
        end
        bvalid <= 1'b1;
        bit_v  <= b;
        bpre   <= pre;
        bpay   <= pay;
        blast  <= last;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 300);
        if (n >= 300) give_up();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        bus_wr(4'h0, 8'h7F);
        bus_wr(4'h1, 8'h07);
        bus_wr(4'h2, 8'h60);
        bus_wr(4'h3, 8'hFF);
        bus_rd(4'h0, d);
        check("taps", d, 8'h7F);
        check("taps out", {1'b0, taps}, 8'h7F);
        bus_rd(4'h1, d);
        check("rate select", d, 8'h07);
        bus_rd(4'h2, d);
        check("rotation", d, 8'h60);
        check("rx rotation", {7'h00, rxrev}, 8'h01);
        bus_rd(4'h3, d);
        check("status idle", d, 8'h00);
        bus_rd(4'hF, d);
        check("unmapped", d, 8'h00);
    endtask

    task automatic t_freeze();
        ce <= 1'b0;
        bus_wr(4'h0, 8'h15);
        ce <= 1'b1;
        bus_rd(4'h0, d);
        check("taps frozen", d, 8'h7F);
    endtask

    task automatic t_pkt(logic [1:0] r, logic k, logic [6:0] t, logic v, logic [23:0] dat);
        int n;
        bus_wr(4'h0, {1'b0, t});
        bus_wr(4'h1, {5'h00, k, r});
        bus_wr(4'h2, {2'h0, v, 5'h00});
        {rate, key, tp, rev} = {r, k, t, v};
        s     = 7'h6C;
        {q, odd, grp_n} = '0;
        exq.delete();
        up.chips.delete();
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 4; i++)
            send(1'b0, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 24; i++)
            send(dat[i], 1'b0, i > 7, i == 7);
        bvalid <= 1'b0;
        n = 0;
        while (up.chips.size() < exq.size() && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) give_up();
        check("chip count", 8'(up.chips.size()), 8'(exq.size()));
        for (int i = 0; i < exq.size() && i < up.chips.size(); i++)
            check("chip", {6'h00, up.chips[i]}, {6'h00, exq[i]});
        bus_rd(4'h3, d);
        check("latched mode", {5'h00, d[6:4]}, {5'h00, r, k});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        check("ready in reset", {7'h00, ready}, 8'h00);
        rstn <= 1'b1;
        t_regs();
        t_freeze();
        t_pkt(2'h0, 1'b0, 7'h00, 1'b0, 24'h5A_3C96);
        t_pkt(2'h0, 1'b0, 7'h48, 1'b0, 24'hC3_17E2);
        t_pkt(2'h1, 1'b0, 7'h48, 1'b0, 24'h96_4B1D);
        t_pkt(2'h1, 1'b0, 7'h48, 1'b1, 24'h2F_D870);
        t_pkt(2'h2, 1'b0, 7'h48, 1'b0, 24'hE1_65A9);
        t_pkt(2'h3, 1'b0, 7'h48, 1'b0, 24'h3B_C40F);
        t_pkt(2'h2, 1'b1, 7'h48, 1'b0, 24'h74_9E53);
        t_pkt(2'h3, 1'b1, 7'h48, 1'b1, 24'hA8_2DB6);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        check("taps after reset", {1'b0, taps}, 8'h00);
        check("ready after reset", {7'h00, ready}, 8'h00);
        wrap_up();
    end
endmodule // tb_dsss_tx_scrambler_modulator
